// File: cpsm_cell_model.sv
// comparator model of cell and sense pin
`timescale 1ns/1ps
`default_nettype none
module cpsm_cell_model #(
  parameter int OV = 4300,
  parameter int OVR = 4200,
  parameter int UV = 2500,
  parameter int UVR = 2800,
  parameter int CHG = -1300,
  parameter int OC1 = 100,
  parameter int OC2 = 500,
  parameter int SHT = 1500
) (
  input var int cellMv,
  input var int senseMv,
  input wire cpsm_pkg::cpsm_gate_t gateOut,
  output var cpsm_pkg::cpsm_cmp_t cmp
);
  // ----
  // comparators
  // ----
  always_comb begin
    cmp.ovHigh = cellMv > OV + (gateOut.ovRaise ? 50 : 0);
    cmp.ovRelease = cellMv < OVR;
    cmp.uvLow = cellMv < UV;
    cmp.uvRelease = cellMv >= UVR;
    cmp.chgDetect = senseMv < CHG;
    cmp.oc1 = senseMv >= OC1;
    cmp.oc2 = senseMv >= OC2;
    cmp.shortDet = senseMv >= SHT;
    cmp.nearSupply = cellMv - senseMv < 1300;
  end
endmodule
`default_nettype wire

// File: cpsm_ctrl.sv
// cell protection state machine with apb control and status
// ----------------------------------------
// ----------------------------------------
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_defs.svh"

module cpsm_ctrl #(
  parameter int unsigned OSC_DIV = `CPSM_CLK_HZ / `CPSM_OSC_HZ
) (
  input wire logic clock,
  input wire logic rstn,
  input wire cpsm_pkg::cpsm_cmp_t cmpIn,
  output var cpsm_pkg::cpsm_gate_t gateOut,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CPSM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [`CPSM_OVC_W-1:0] OVC_TICKS = `CPSM_OVC_W'(`CPSM_TICKS(`CPSM_T_OVC_MS));
  localparam logic [`CPSM_UVD_W-1:0] UVD_TICKS = `CPSM_UVD_W'(`CPSM_TICKS(`CPSM_T_UVD_MS));
  localparam logic [`CPSM_OC_W-1:0] OC1_TICKS = `CPSM_OC_W'(`CPSM_TICKS(`CPSM_T_OC1_MS));
  localparam logic [`CPSM_OC_W-1:0] OC2_TICKS = `CPSM_OC_W'(`CPSM_TICKS(`CPSM_T_OC2_MS));
  localparam logic [`CPSM_DIV_W-1:0] DIV_LAST = `CPSM_DIV_W'(OSC_DIV - 1);

  localparam cpsm_pkg::cpsm_regs_t RESET_C = '{
    st: cpsm_pkg::ST_NORMAL,
    ctrl: `CPSM_CTRL_RST,
    gate: '{chargeGateOut: 1'b1, dischargeGateOut: 1'b1, default: 1'b0},
    default: '0
  };

  cpsm_pkg::cpsm_regs_t r_q;
  cpsm_pkg::cpsm_regs_t r_d;

  assign gateOut = r_q.gate;
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    cpsm_pkg::cpsm_cmp_t f;
    logic ocAct;
    logic ocTrip;
    logic setup;
    logic mapped;
    f = r_q.filt;
    ocAct = 1'b0;
    ocTrip = 1'b0;
    setup = 1'b0;
    mapped = 1'b0;
    r_d = r_q;

    r_d.s1 = cmpIn;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    // a bit moves only once stages two and three agree
    r_d.filt = (r_q.s2 & r_q.s3) | (r_q.filt & (r_q.s2 | r_q.s3));

    r_d.tick = (r_q.div == DIV_LAST);
    r_d.div = r_d.tick ? '0 : r_q.div + 1'b1;

    r_d.ovcCnt = '0;
    r_d.uvdCnt = '0;
    r_d.ocCnt = '0;
    if (r_q.st == cpsm_pkg::ST_NORMAL) begin
      ocAct = f.oc1 | f.oc2;
      if (ocAct) begin
        r_d.ocCnt = r_q.ocCnt + {{(`CPSM_OC_W-1){1'b0}}, r_q.tick && r_q.ocCnt != OC1_TICKS};
      end
      if (f.ovHigh) begin
        r_d.ovcCnt = r_q.ovcCnt + {{(`CPSM_OVC_W-1){1'b0}}, r_q.tick && r_q.ovcCnt != OVC_TICKS};
      end
      if (f.uvLow) begin
        r_d.uvdCnt = r_q.uvdCnt + {{(`CPSM_UVD_W-1){1'b0}}, r_q.tick && r_q.uvdCnt != UVD_TICKS};
      end
      ocTrip = f.shortDet || (f.oc1 && r_q.ocCnt >= OC1_TICKS)
        || (f.oc2 && r_q.ocCnt >= OC2_TICKS);
    end

    case (r_q.st)
      cpsm_pkg::ST_NORMAL: begin
        if (ocTrip) begin
          r_d.st = cpsm_pkg::ST_OVERCURRENT;
        end else if (f.uvLow && r_q.uvdCnt >= UVD_TICKS) begin
          r_d.st = cpsm_pkg::ST_OVERDISCH;
          r_d.chargerSeen = 1'b0;
        end else if (f.ovHigh && r_q.ovcCnt >= OVC_TICKS) begin
          r_d.st = cpsm_pkg::ST_OVERCHARGE;
          r_d.gate.ovRaise = 1'b0;
        end
      end
      cpsm_pkg::ST_OVERCURRENT: begin
        if (!f.oc1 && !f.oc2 && !f.shortDet) begin
          r_d.st = cpsm_pkg::ST_NORMAL;
        end
      end
      cpsm_pkg::ST_OVERCHARGE: begin
        if (f.shortDet) begin
          r_d.st = cpsm_pkg::ST_OVERCURRENT;
        end else if (f.ovRelease && !r_q.gate.ovRaise) begin
          r_d.st = cpsm_pkg::ST_NORMAL;
        end else if (r_q.ctrl.hyst) begin
          if (f.oc1 && !f.ovHigh) begin
            r_d.st = cpsm_pkg::ST_NORMAL;
          end
        end else begin
          // raise threshold on load, then compare
          if (f.oc1) begin
            r_d.gate.ovRaise = 1'b1;
          end
          // release on the first tick with ovRaise set and filtered ovHigh low, which can come before the raised compare has passed the sync stages
          if (r_q.gate.ovRaise && r_q.tick && !f.ovHigh) begin
            r_d.st = cpsm_pkg::ST_NORMAL;
          end
        end
      end
      cpsm_pkg::ST_OVERDISCH: begin
        if (f.chgDetect) begin
          r_d.chargerSeen = 1'b1;
        end
        // charger seen, release at low threshold
        if (r_q.chargerSeen ? !f.uvLow : f.uvRelease) begin
          r_d.st = cpsm_pkg::ST_NORMAL;
        // pulled near supply, go to sleep
        end else if (r_q.ctrl.pdEn && f.nearSupply) begin
          r_d.st = cpsm_pkg::ST_POWERDOWN;
        end
      end
      cpsm_pkg::ST_POWERDOWN: begin
        if (!f.nearSupply) begin
          r_d.st = cpsm_pkg::ST_OVERDISCH;
          r_d.chargerSeen = 1'b1;
        end
      end
      default: begin
        r_d.st = cpsm_pkg::ST_NORMAL;
      end
    endcase
    if (r_d.st != cpsm_pkg::ST_OVERCHARGE) begin
      r_d.gate.ovRaise = 1'b0;
    end

    // ----------------------------------------
    // outputs from next state
    // ----------------------------------------
    // gates follow state
    r_d.gate.chargeGateOut = (r_d.st != cpsm_pkg::ST_OVERCHARGE);
    r_d.gate.dischargeGateOut = (r_d.st == cpsm_pkg::ST_NORMAL)
      || (r_d.st == cpsm_pkg::ST_OVERCHARGE);
    r_d.gate.sensePulldown = (r_d.st == cpsm_pkg::ST_OVERCURRENT);
    r_d.gate.sensePullup = (r_d.st == cpsm_pkg::ST_OVERDISCH)
      || (r_d.st == cpsm_pkg::ST_POWERDOWN);
    r_d.gate.sleepMode = (r_d.st == cpsm_pkg::ST_POWERDOWN);

    // ----------------------------------------
    // apb slave, one wait free access cycle
    // ----------------------------------------
    setup = psel && !penable;
    mapped = (paddr == `CPSM_REG_CTRL) || (paddr == `CPSM_REG_STAT);
    r_d.pready = setup;
    if (setup) begin
      r_d.pslverr = !mapped;
      r_d.prdata = '0;
      if (!pwrite && paddr == `CPSM_REG_CTRL) begin
        r_d.prdata[`CPSM_CTRL_HYST] = r_q.ctrl.hyst;
        r_d.prdata[`CPSM_CTRL_PDEN] = r_q.ctrl.pdEn;
      end else if (!pwrite && paddr == `CPSM_REG_STAT) begin
        r_d.prdata[4:0] = r_q.st;
        r_d.prdata[`CPSM_STAT_GATE_LSB +: 6] = r_q.gate;
        r_d.prdata[`CPSM_STAT_SEEN] = r_q.chargerSeen;
        r_d.prdata[`CPSM_STAT_CMP_LSB +: 9] = r_q.filt;
      end
    end else if (!psel) begin
      r_d.pslverr = 1'b0;
    end
    // write lands on the completing edge only
    if (psel && penable && r_q.pready && pwrite && paddr == `CPSM_REG_CTRL) begin
      r_d.ctrl.hyst = pwdata[`CPSM_CTRL_HYST];
      r_d.ctrl.pdEn = pwdata[`CPSM_CTRL_PDEN];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r_q <= RESET_C;
    end else begin
      r_q <= r_d;
    end
  end

endmodule
`default_nettype wire

// File: cpsm_ctrl_assertions.sv
// concurrent checks on the controller ports
`timescale 1ns/1ps
`default_nettype none
module cpsm_ctrl_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire cpsm_pkg::cpsm_cmp_t cmpIn,
  input wire cpsm_pkg::cpsm_gate_t gateOut,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_OC_PULLDOWN: assert property (gateOut.sensePulldown |-> !gateOut.dischargeGateOut)
    else $error("pulldown with discharge on");
  AST_OD_PULLUP: assert property (gateOut.sensePullup |-> !gateOut.dischargeGateOut)
    else $error("pullup with discharge on");
  AST_SLEEP: assert property (gateOut.sleepMode |-> gateOut.sensePullup)
    else $error("sleep without pullup");
  AST_PD_EXIT: assert property ($fell(gateOut.sleepMode) |-> !gateOut.dischargeGateOut)
    else $error("discharge on at wake");
  AST_CHG_OFF: assert property ($fell(gateOut.chargeGateOut) |-> gateOut.dischargeGateOut)
    else $error("charge off with discharge off");
  AST_SHORT: assert property (cmpIn.shortDet [*8] |-> !gateOut.dischargeGateOut)
    else $error("short ignored");
  AST_OC_EXIT: assert property (!(cmpIn.oc1 || cmpIn.oc2 || cmpIn.shortDet) [*8]
    |-> !gateOut.sensePulldown)
    else $error("overcurrent not released");
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
endmodule
bind cpsm_ctrl cpsm_ctrl_checker cpsm_ctrl_checker_inst (.clock(clock), .rstn(rstn),
  .cmpIn(cmpIn), .gateOut(gateOut), .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

// File: cpsm_defs.svh
// constants for the cell protection state machine
`ifndef CPSM_DEFS_SVH
`define CPSM_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CPSM_CLK_HZ 25000000
`define CPSM_OSC_HZ 2000
`define CPSM_T_OVC_MS 1000
`define CPSM_T_UVD_MS 125
`define CPSM_T_OC1_MS 8
`define CPSM_T_OC2_MS 2
`define CPSM_TICKS(ms) (((ms) * `CPSM_OSC_HZ) / 1000)

// ----------------------------------------
// counter widths
// ----------------------------------------
`define CPSM_DIV_W 14
`define CPSM_OVC_W 11
`define CPSM_UVD_W 8
`define CPSM_OC_W 5

// ----------------------------------------
// register map
// ----------------------------------------
`define CPSM_ADDR_W 12
`define CPSM_REG_CTRL 12'h000
`define CPSM_REG_STAT 12'h004
`define CPSM_CTRL_HYST 0
`define CPSM_CTRL_PDEN 1
`define CPSM_CTRL_RST 2'h3
`define CPSM_STAT_GATE_LSB 8
`define CPSM_STAT_SEEN 14
`define CPSM_STAT_CMP_LSB 16

`endif

// File: cpsm_pkg.sv
// types for the cell protection state machine
`default_nettype none
`include "cpsm_defs.svh"

package cpsm_pkg;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_OVERCURRENT = 5'h02,
    ST_OVERCHARGE = 5'h04,
    ST_OVERDISCH = 5'h08,
    ST_POWERDOWN = 5'h10
  } cpsm_state_t;

  // comparator outputs, all active high
  typedef struct packed {
    logic ovHigh;
    logic ovRelease;
    logic uvLow;
    logic uvRelease;
    logic chgDetect;
    logic oc1;
    logic oc2;
    logic shortDet;
    logic nearSupply;
  } cpsm_cmp_t;

  typedef struct packed {
    logic chargeGateOut;
    logic dischargeGateOut;
    logic sensePulldown;
    logic sensePullup;
    logic sleepMode;
    logic ovRaise;
  } cpsm_gate_t;

  typedef struct packed {
    logic pdEn;
    logic hyst;
  } cpsm_ctrl_t;

  typedef struct packed {
    cpsm_state_t st;
    cpsm_cmp_t s1;
    cpsm_cmp_t s2;
    cpsm_cmp_t s3;
    cpsm_cmp_t filt;
    logic [`CPSM_DIV_W-1:0] div;
    logic tick;
    logic [`CPSM_OVC_W-1:0] ovcCnt;
    logic [`CPSM_UVD_W-1:0] uvdCnt;
    logic [`CPSM_OC_W-1:0] ocCnt;
    logic chargerSeen;
    cpsm_ctrl_t ctrl;
    cpsm_gate_t gate;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cpsm_regs_t;

endpackage
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the protection controller
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_defs.svh"
module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [`CPSM_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  int cellMv = 3700, senseMv = 0, n_errors = 0, cmp_count = 0;
  cpsm_pkg::cpsm_cmp_t cmpIn;
  cpsm_pkg::cpsm_gate_t gateOut;
  always #20 clock = ~clock;
  cpsm_cell_model cpsm_cell_model_inst (.cellMv(cellMv), .senseMv(senseMv),
    .gateOut(gateOut), .cmp(cmpIn));
  // short divider keeps the long delays affordable
  cpsm_ctrl #(.OSC_DIV(4)) cpsm_ctrl_inst (.clock(clock), .rstn(rstn), .cmpIn(cmpIn),
    .gateOut(gateOut), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----
  // helpers
  // ----
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  function automatic logic [5:0] gx(input logic c, d, p, u, s);
    return {c, d, p, u, s, 1'b0};
  endfunction
  task automatic chkGate(input int n, input logic [5:0] e);
    repeat (n) @(posedge clock);
    @(negedge clock);
    chk({26'h0, gateOut}, {26'h0, e});
  endtask
  task automatic setIn(input int c, input int s);
    @(posedge clock);
    cellMv <= c;
    senseMv <= s;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    // request holds until ready is seen at a rising edge, giving up after 20 edges
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    #(40 * 40000);
    n_errors++;
    summarize;
  end
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(12));
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    chkGate(2, gx(1, 1, 0, 0, 0));
    apb(0, `CPSM_REG_CTRL, 0);
    chk(rd, 32'h3);
    apb(0, 12'h008, 0);
    chk({31'h0, er}, 32'h1);
    setIn(3700, 600);
    chkGate(30, gx(1, 0, 1, 0, 0));
    setIn(3700, 0);
    chkGate(12, gx(1, 1, 0, 0, 0));
    setIn(3700, 300);
    chkGate(50, gx(1, 1, 0, 0, 0));
    chkGate(40, gx(1, 0, 1, 0, 0));
    setIn(3700, 2000);
    chkGate(12, gx(1, 0, 1, 0, 0));
    repeat (10) begin
      setIn($urandom_range(2600, 4200), 300);
      repeat ($urandom_range(3, 40)) @(posedge clock);
      setIn(3700, 0);
      chkGate(10, gx(1, 1, 0, 0, 0));
    end
    setIn(4400, 0);
    chkGate(7900, gx(1, 1, 0, 0, 0));
    chkGate(200, gx(0, 1, 0, 0, 0));
    setIn(4400, 300);
    chkGate(100, gx(0, 1, 0, 0, 0));
    setIn(4250, 50);
    chkGate(20, gx(0, 1, 0, 0, 0));
    setIn(4250, 300);
    chkGate(12, gx(1, 1, 0, 0, 0));
    apb(1, `CPSM_REG_CTRL, 32'h2);
    apb(0, `CPSM_REG_CTRL, 0);
    chk(rd, 32'h2);
    setIn(4320, 0);
    chkGate(8200, gx(0, 1, 0, 0, 0));
    setIn(4320, 300);
    chkGate(30, gx(1, 1, 0, 0, 0));
    setIn(2400, 0);
    chkGate(1100, gx(1, 0, 0, 1, 0));
    apb(0, `CPSM_REG_STAT, 0);
    chk(rd, 32'h00C02408);
    chk({31'h0, er}, 32'h0);
    setIn(2400, 1400);
    chkGate(12, gx(1, 0, 0, 1, 1));
    setIn(2400, -2000);
    chkGate(12, gx(1, 0, 0, 1, 0));
    setIn(2600, -2000);
    chkGate(12, gx(1, 1, 0, 0, 0));
    setIn(2400, 0);
    chkGate(1100, gx(1, 0, 0, 1, 0));
    setIn(2600, 0);
    chkGate(30, gx(1, 0, 0, 1, 0));
    setIn(2900, 0);
    chkGate(12, gx(1, 1, 0, 0, 0));
    summarize;
  end
endmodule
`default_nettype wire
